// [core/cwgc_pkg.sv]
// constants of the complementary waveform control block: register map, fields, resets, modes.
// assumes a 32-bit apb slave with one aligned word per 8-bit register.
package cwgc_pkg;
  localparam int          DB_W          = 6;
  localparam int          SRC_W         = 6;
  localparam int          IRQ_W         = 3;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL0    = 8'h00;
  localparam logic [7:0]  ADDR_CTRL1    = 8'h04;
  localparam logic [7:0]  ADDR_SDCTRL   = 8'h08;
  localparam logic [7:0]  ADDR_SDSEL    = 8'h0c;
  localparam logic [7:0]  ADDR_DBR      = 8'h10;
  localparam logic [7:0]  ADDR_DBF      = 8'h14;
  localparam logic [7:0]  ADDR_OUTSEL   = 8'h18;
  localparam logic [7:0]  ADDR_IRQSTAT  = 8'h1c;
  localparam logic [7:0]  ADDR_IRQMASK  = 8'h20;
  // field positions
  localparam int          EN_BIT        = 7;
  localparam int          LD_BIT        = 6;
  localparam int          IN_BIT        = 5;
  localparam int          SD_BIT        = 7;
  localparam int          REN_BIT       = 6;
  localparam int          PAIR_BD_OVERRIDE_LEVEL_LSB      = 4;
  localparam int          PAIR_AC_OVERRIDE_LEVEL_LSB      = 2;
  // reset values, and the sdsel bits that always read as one
  localparam logic [1:0]  PAIR_BD_OVERRIDE_LEVEL_RST      = 2'h1;
  localparam logic [1:0]  PAIR_AC_OVERRIDE_LEVEL_RST      = 2'h1;
  localparam logic [7:0]  SDSEL_ONES    = 8'h88;
  // mode codes
  localparam logic [2:0]  MODE_STEER    = 3'h0;
  localparam logic [2:0]  MODE_SSTEER   = 3'h1;
  localparam logic [2:0]  MODE_FWD      = 3'h2;
  localparam logic [2:0]  MODE_REV      = 3'h3;
  localparam logic [2:0]  MODE_HALF     = 3'h4;
  localparam logic [2:0]  MODE_PP       = 3'h5;
  // override level codes
  localparam logic [1:0]  OVR_ONE       = 2'h3;
  localparam logic [1:0]  OVR_ZERO      = 2'h2;
  localparam logic [1:0]  OVR_TRI       = 2'h1;
  localparam logic [1:0]  OVR_INACT     = 2'h0;
  // interrupt status bits
  localparam int          IRQ_SD        = 0;
  localparam int          IRQ_RESTART   = 1;
  localparam int          IRQ_LOAD      = 2;
endpackage

// [core/cwgc_db_if.sv]
// link between the control core and one dead-band delay unit.
// assumes both ends run on pclk.
`timescale 1ns/1ns
interface cwgc_db_if;
  import cwgc_pkg::*;
  logic [DB_W-1:0] count;
  logic            sig_in;
  logic            sig_out;
  modport unit (input count, input sig_in, output sig_out);
  modport ctrl (output count, output sig_in, input sig_out);
endinterface

// [core/cwgc_deadband.sv]
// dead-band unit: delays each rising edge of sig_in by count+1 clocks, falls one clock after sig_in.
// assumes sig_in is synchronous to pclk.
`timescale 1ns/1ns
module cwgc_deadband
  import cwgc_pkg::*;
(
  input wire logic  pclk,
  input wire logic  presetn,
  cwgc_db_if.unit   db
);
  logic [DB_W-1:0] cnt;
  logic            out_q;
  logic [DB_W-1:0] next_cnt;
  logic            next_out_q;

  // a pulse shorter than the count never reaches the output
  always_comb begin
    next_cnt   = cnt;
    next_out_q = out_q;
    if (!db.sig_in) begin
      next_cnt   = '0;
      next_out_q = 1'b0;
    end else if (!out_q) begin
      if (cnt >= db.count) begin
        next_out_q = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt   <= '0;
      out_q <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      out_q <= next_out_q;
    end
  end

  assign db.sig_out = out_q;
endmodule

// [core/cwgc_top.sv]
// complementary waveform control core with apb register file and interrupt.
// assumes wave_in and shutdown_source are synchronous to pclk.
`timescale 1ns/1ns
module cwgc_top
  import cwgc_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             wave_in,
  input  wire logic [SRC_W-1:0] shutdown_source,
  input  wire logic             sleep_req,
  input  wire logic             input_active,
  input  wire logic             hfosc_selected,
  output logic      [3:0]       out_level,
  output logic      [3:0]       out_oe,
  output logic                  osc_keep_on,
  output logic                  irq
);
  // register state
  logic             en, ld, sd, ren, hold, in_q, pp_phase;
  logic [2:0]       mode;
  logic [3:0]       pol, oe_sel, steer, steer_act;
  logic [1:0]       pair_bd_override_level, pair_ac_override_level;
  logic [SRC_W-1:0] src_sel;
  logic [DB_W-1:0]  dbr_buf, dbf_buf, dbr_act, dbf_act;
  logic [IRQ_W-1:0] irq_stat, irq_mask;
  logic             next_en, next_ld, next_sd, next_ren, next_hold, next_pp_phase;
  logic [2:0]       next_mode;
  logic [3:0]       next_pol, next_oe_sel, next_steer, next_steer_act;
  logic [1:0]       next_pair_bd_override_level, next_pair_ac_override_level;
  logic [SRC_W-1:0] next_src_sel;
  logic [DB_W-1:0]  next_dbr_buf, next_dbf_buf, next_dbr_act, next_dbf_act;
  logic [IRQ_W-1:0] next_irq_stat, next_irq_mask, irq_ev;
  logic [31:0]      next_prdata;
  logic             next_pready, next_pslverr, next_irq, next_osc;
  logic [3:0]       next_out_level, next_out_oe, raw, steer_sel;
  logic             acc, wr, rise, fall, src_act, steering, hit;
  logic [7:0]       rd_byte;

  cwgc_db_if db_r ();
  cwgc_db_if db_f ();

  cwgc_deadband u_db_rise (.pclk(pclk), .presetn(presetn), .db(db_r));
  cwgc_deadband u_db_fall (.pclk(pclk), .presetn(presetn), .db(db_f));

  // apb access completes on the edge that samples pready high
  assign acc      = psel & penable & pready;
  assign wr       = acc & pwrite;
  assign rise     = wave_in & ~in_q;
  assign fall     = ~wave_in & in_q;
  assign src_act  = |(shutdown_source & src_sel); // level, never edge
  assign steering = (mode == MODE_STEER) || (mode == MODE_SSTEER);
  assign steer_sel = (mode == MODE_SSTEER) ? steer_act : steer;

  // dead-band feeds: rising unit times a/b-leading edges, falling unit the complement except in forward mode, where it takes the input
  always_comb begin
    db_r.count  = dbr_act;
    db_f.count  = dbf_act;
    db_r.sig_in = wave_in;
    db_f.sig_in = (mode == MODE_FWD) ? wave_in : ~wave_in;
  end

  // apb read mux and slave answer: one wait state, unmapped address flags an error
  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      ADDR_CTRL0:   rd_byte = {en, ld, 3'h0, mode};
      ADDR_CTRL1:   rd_byte = {2'h0, wave_in, 1'b0, pol};
      ADDR_SDCTRL:  rd_byte = {sd, ren, pair_bd_override_level, pair_ac_override_level, 2'h0};
      ADDR_SDSEL:   rd_byte = SDSEL_ONES | {1'b0, src_sel[5:3], 1'b0, src_sel[2:0]};
      ADDR_DBR:     rd_byte = {2'h0, dbr_buf};
      ADDR_DBF:     rd_byte = {2'h0, dbf_buf};
      ADDR_OUTSEL:  rd_byte = {steer, oe_sel};
      ADDR_IRQSTAT: rd_byte = {5'h00, irq_stat};
      ADDR_IRQMASK: rd_byte = {5'h00, irq_mask};
      default:      hit = 1'b0;
    endcase
    next_pready  = psel & penable & ~pready;
    next_pslverr = next_pready & ~hit;
    next_prdata  = (next_pready & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
  end

  // control, shutdown and buffer-load state
  always_comb begin
    next_en       = en;
    next_ld       = ld;
    next_mode     = mode;
    next_pol      = pol;
    next_sd       = sd;
    next_ren      = ren;
    next_pair_bd_override_level     = pair_bd_override_level;
    next_pair_ac_override_level     = pair_ac_override_level;
    next_src_sel  = src_sel;
    next_dbr_buf  = dbr_buf;
    next_dbf_buf  = dbf_buf;
    next_dbr_act  = dbr_act;
    next_dbf_act  = dbf_act;
    next_oe_sel   = oe_sel;
    next_steer    = steer;
    next_irq_mask = irq_mask;
    next_pp_phase = fall ? ~pp_phase : pp_phase;
    next_steer_act = rise ? steer : steer_act; // synchronous steering takes effect on rising input
    irq_ev        = '0;
    // buffered dead-band values move on the next input edge, then the request clears
    if (ld && (rise || fall)) begin
      next_dbr_act     = dbr_buf;
      next_dbf_act     = dbf_buf;
      next_ld          = 1'b0;
      irq_ev[IRQ_LOAD] = 1'b1;
    end
    // auto-restart clears the flag once no selected source is active
    if (ren && sd && !src_act) begin
      next_sd = 1'b0;
    end
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL0: begin
          next_en   = pwdata[EN_BIT];
          next_ld   = pwdata[LD_BIT] & en | next_ld;  // only when already enabled
          next_mode = pwdata[2:0];
        end
        ADDR_CTRL1: next_pol = pwdata[3:0];
        ADDR_SDCTRL: begin
          next_ren  = pwdata[REN_BIT];
          next_pair_bd_override_level = pwdata[PAIR_BD_OVERRIDE_LEVEL_LSB +: 2];
          next_pair_ac_override_level = pwdata[PAIR_AC_OVERRIDE_LEVEL_LSB +: 2];
          // a clear is refused while a selected source stays active
          if (pwdata[SD_BIT]) begin
            next_sd = 1'b1;
          end else if (!src_act) begin
            next_sd = 1'b0;
          end
        end
        ADDR_SDSEL: next_src_sel = {pwdata[6:4], pwdata[2:0]};
        ADDR_DBR: begin
          next_dbr_buf = pwdata[DB_W-1:0];
          if (!en) begin
            next_dbr_act = pwdata[DB_W-1:0];
          end
        end
        ADDR_DBF: begin
          next_dbf_buf = pwdata[DB_W-1:0];
          if (!en) begin
            next_dbf_act = pwdata[DB_W-1:0];
          end
        end
        ADDR_OUTSEL: begin
          next_oe_sel = pwdata[3:0];
          next_steer  = pwdata[7:4];
        end
        ADDR_IRQMASK: next_irq_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (!next_en) begin
      next_ld = 1'b0;
    end
    // a selected source sets the flag and wins over any clear
    if (src_act) begin
      next_sd = 1'b1;
    end
    irq_ev[IRQ_SD] = next_sd & ~sd;
    // overrides stay until the first rising input after the flag clears
    next_hold = sd | (hold & ~rise);
    irq_ev[IRQ_RESTART] = hold & ~next_hold;
    // write-one-to-clear; a new event in the same cycle wins
    next_irq_stat = irq_stat;
    if (wr && paddr == ADDR_IRQSTAT) begin
      next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | irq_ev;
    next_irq      = |(next_irq_stat & next_irq_mask);
    next_osc      = sleep_req & en & input_active & hfosc_selected;
  end

  // waveform and output stage
  always_comb begin
    raw = 4'h0;
    unique case (mode)
      MODE_STEER, MODE_SSTEER: raw = {4{wave_in}} & steer_sel;
      MODE_FWD:  raw = {db_f.sig_out, 2'b00, 1'b1};
      MODE_REV:  raw = {2'b01, db_r.sig_out, 1'b0};
      MODE_HALF: raw = {db_f.sig_out, db_r.sig_out, db_f.sig_out, db_r.sig_out};
      MODE_PP:   raw = {2'b00, wave_in & pp_phase, wave_in & ~pp_phase};
      default:   raw = 4'h0; // reserved codes stay inactive
    endcase
    next_out_oe = oe_sel;
    // polarity applies to the generated waveform and is the output level while disabled
    next_out_level = en ? (raw ^ pol) : pol;
    for (int i = 0; i < 4; i++) begin
      // steering shutdown touches only steered pins; polarity is ignored here except by the inactive-level code
      if ((sd || hold) && !(steering && !steer_sel[i])) begin
        unique case ((i % 2 == 1) ? pair_bd_override_level : pair_ac_override_level) // b/d vs a/c pairs
          OVR_ONE:   next_out_level[i] = 1'b1;
          OVR_ZERO:  next_out_level[i] = 1'b0;
          OVR_TRI: begin
            next_out_level[i] = 1'b0;
            next_out_oe[i]    = 1'b0;
          end
          OVR_INACT: next_out_level[i] = pol[i];
        endcase
      end
    end
  end

  // register all state; outputs come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en <= 1'b0; ld <= 1'b0; mode <= MODE_STEER; pol <= 4'h0;
      sd <= 1'b0; ren <= 1'b0; pair_bd_override_level <= PAIR_BD_OVERRIDE_LEVEL_RST; pair_ac_override_level <= PAIR_AC_OVERRIDE_LEVEL_RST;
      src_sel <= '0; dbr_buf <= '0; dbf_buf <= '0; dbr_act <= '0; dbf_act <= '0;
      oe_sel <= 4'h0; steer <= 4'h0; steer_act <= 4'h0; irq_stat <= '0; irq_mask <= '0;
      hold <= 1'b1; // start-up comes out of the shutdown state
      in_q <= 1'b0; pp_phase <= 1'b0;
      prdata <= 32'h00000000; pready <= 1'b0; pslverr <= 1'b0;
      out_level <= 4'h0; out_oe <= 4'h0; osc_keep_on <= 1'b0; irq <= 1'b0;
    end else begin
      en <= next_en; ld <= next_ld; mode <= next_mode; pol <= next_pol;
      sd <= next_sd; ren <= next_ren; pair_bd_override_level <= next_pair_bd_override_level; pair_ac_override_level <= next_pair_ac_override_level;
      src_sel <= next_src_sel; dbr_buf <= next_dbr_buf; dbf_buf <= next_dbf_buf;
      dbr_act <= next_dbr_act; dbf_act <= next_dbf_act;
      oe_sel <= next_oe_sel; steer <= next_steer; steer_act <= next_steer_act;
      irq_stat <= next_irq_stat; irq_mask <= next_irq_mask;
      hold <= next_hold; in_q <= wave_in; pp_phase <= next_pp_phase;
      prdata <= next_prdata; pready <= next_pready; pslverr <= next_pslverr;
      out_level <= next_out_level; out_oe <= next_out_oe;
      osc_keep_on <= next_osc; irq <= next_irq;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_flag_clear;
    !sd && hold;
  endsequence
  sequence s_no_edge;
    !rise;
  endsequence

  a_osc_keep_on: assert property ((sleep_req && en && input_active && hfosc_selected) |=> osc_keep_on)
    else $error("oscillator not kept on");
  a_override_pair_ac: assert property ((sd && pair_ac_override_level == OVR_ONE && !steering) |=> (out_level[0] && out_level[2]))
    else $error("a/c override not one");
  a_pol_no_override: assert property ((sd && pair_ac_override_level == OVR_ZERO && pol[0] && !steering) |=> !out_level[0])
    else $error("polarity changed override");
  a_tristate_bd: assert property ((sd && pair_bd_override_level == OVR_TRI && !steering) |=> (!out_oe[1] && !out_oe[3]))
    else $error("b/d not tristated");
  a_clear_blocked: assert property ((wr && paddr == ADDR_SDCTRL && src_act) |=> sd)
    else $error("shutdown cleared while source active");
  a_auto_restart: assert property ((ren && sd && !src_act && !wr && !$rose(sd)) |=> !sd)
    else $error("auto-restart missed");
  a_source_level: assert property (src_act |=> sd [*1] ##1 (sd || !$past(src_act)))
    else $error("source did not hold shutdown");
  a_hold_until_rise: assert property ((s_flag_clear ##0 s_no_edge) |=> hold)
    else $error("override released before rising input");
  a_hold_release: assert property ((s_flag_clear ##0 rise) |=>
                                   !hold ##1 ($past(sd) || out_oe == $past(oe_sel)))
    else $error("override not released on rising input");
  a_ld_needs_en: assert property ((wr && paddr == ADDR_CTRL0 && !en && !ld) |=> !ld)
    else $error("load set while disabled");
  a_ld_clears: assert property ((ld && (rise || fall) && !wr) |=> (!ld && dbr_act == $past(dbr_buf)))
    else $error("load not transferred");
  a_reserved_idle: assert property ((en && mode[2:1] == 2'b11 && !sd && !hold) |=> out_level == $past(pol))
    else $error("reserved mode not inactive");
  a_disabled_idle: assert property ((!en && !sd && !hold) |=> out_level == $past(pol))
    else $error("disabled outputs not inactive");
  a_steer_pol: assert property ((en && mode == MODE_STEER && steer[0] && !sd && !hold) |=>
                                out_level[0] == ($past(wave_in) ^ $past(pol[0])))
    else $error("steered output polarity wrong");
endmodule

// [dv/cwgc_bridge_model.sv]
// far-side model: gate drivers of the bridge switches, watching the four outputs.
// assumes out_oe high means the core drives the pin; an undriven gate has no pull.
`timescale 1ns/1ns
module cwgc_bridge_model (
  input  wire logic       pclk,
  input  wire logic [3:0] out_level,
  input  wire logic [3:0] out_oe,
  output logic      [3:0] pin
);
  logic [3:0] last;

  // remember what each gate saw on the previous cycle
  always_ff @(posedge pclk) begin
    last <= pin;
  end

  // a floating gate toggles, so no stale level can pass for a driven one
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin[i] = out_oe[i] ? out_level[i] : ~last[i];
    end
  end
endmodule

// [dv/complementary_waveform_control_tb.sv]
// self-checking bench for the waveform control core: apb master, sources, bridge model.
// assumes one 50 MHz clock and an apb slave that answers on its own pready.
`timescale 1ns/1ns
module complementary_waveform_control_tb
  import cwgc_pkg::*;
();
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic             wave_in, sleep_req, input_active, hfosc_selected, osc_keep_on, irq;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [SRC_W-1:0] shutdown_source;
  logic [3:0]       out_level, out_oe, pin;
  int               miscompares, n_tests;

  cwgc_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wave_in(wave_in), .shutdown_source(shutdown_source), .sleep_req(sleep_req),
    .input_active(input_active), .hfosc_selected(hfosc_selected), .out_level(out_level),
    .out_oe(out_oe), .osc_keep_on(osc_keep_on), .irq(irq));
  cwgc_bridge_model bridge (.pclk(pclk), .out_level(out_level), .out_oe(out_oe), .pin(pin));

  // free-running 20 ns clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic end_sim();
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      miscompares++;
      $display("ERROR %0t no pready", $time);
      end_sim();
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // wave input change, then let the registered outputs settle
  task automatic wv(input logic v);
    @(posedge pclk);
    wave_in <= v;
    repeat (3) @(posedge pclk);
  endtask

  task automatic src(input logic [SRC_W-1:0] v);
    @(posedge pclk);
    shutdown_source <= v;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_reset();
    chk(out_oe, 32'h0, "pins float after reset");
    rdc(ADDR_CTRL0, 32'h0, "ctrl0 reset");
    rdc(ADDR_CTRL1, 32'h0, "ctrl1 reset");
    rdc(ADDR_SDCTRL, 32'h14, "shutdown ctrl reset");
    apb(1'b0, 8'hfc, 32'h0);
    chk(er, 32'h1, "unmapped slverr");
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_CTRL0, m);
      rdc(ADDR_CTRL0, m, "mode field");
    end
  endtask

  // configure in the documented order, with the load request handshake
  task automatic t_config();
    wr(ADDR_CTRL0, 32'h00);
    wr(ADDR_CTRL0, 32'h02);
    wr(ADDR_DBR, 32'h01);
    wr(ADDR_DBF, 32'h01);
    wr(ADDR_SDSEL, 32'h02);
    rdc(ADDR_SDSEL, 32'h8a, "source select");
    wr(ADDR_SDCTRL, 32'hac);
    wr(ADDR_CTRL1, 32'h05);
    wr(ADDR_OUTSEL, 32'h0f);
    wr(ADDR_CTRL0, 32'hc2);
    rdc(ADDR_CTRL0, 32'h82, "load with enable refused");
    wr(ADDR_CTRL0, 32'hc2);
    rdc(ADDR_CTRL0, 32'hc2, "load pending");
    wv(1'b1);
    rdc(ADDR_CTRL0, 32'h82, "load done on edge");
    chk(out_level, 32'h5, "override levels, polarity ignored");
    chk(out_oe, 32'hf, "override drives");
    wv(1'b0);
  endtask

  task automatic t_soft_restart();
    src(6'h02);
    wr(ADDR_SDCTRL, 32'h2c);
    rdc(ADDR_SDCTRL, 32'hac, "clear refused, source high");
    src(6'h00);
    wr(ADDR_SDCTRL, 32'h2c);
    rdc(ADDR_SDCTRL, 32'h2c, "software clear");
    chk(out_level, 32'h5, "override held until rise");
    wv(1'b1);
    chk(out_level[0], 32'h0, "forward drive a inverted");
    chk(pin[0], 32'h0, "bridge sees a");
  endtask

  task automatic t_auto_restart();
    wr(ADDR_IRQSTAT, 32'h07);
    wr(ADDR_IRQMASK, 32'h01);
    @(posedge pclk); // irq is registered from the mask written at the access edge
    chk(irq, 32'h0, "irq idle");
    src(6'h02);
    chk(out_level, 32'h5, "source forces override");
    chk(irq, 32'h1, "shutdown irq");
    wr(ADDR_IRQMASK, 32'h00);
    @(posedge pclk);
    chk(irq, 32'h0, "irq masked");
    wr(ADDR_IRQMASK, 32'h01);
    @(posedge pclk);
    chk(irq, 32'h1, "irq unmasked");
    wv(1'b0);
    wr(ADDR_SDCTRL, 32'hec);
    rdc(ADDR_SDCTRL, 32'hec, "auto restart waits for source");
    src(6'h00);
    rdc(ADDR_SDCTRL, 32'h6c, "auto restart clears flag");
    chk(out_level, 32'h5, "override held until rise");
    wv(1'b1);
    chk(out_level[0], 32'h0, "resumed after rise");
    wr(ADDR_IRQSTAT, 32'h07);
    @(posedge pclk);
    chk(irq, 32'h0, "irq cleared");
  endtask

  task automatic t_reserved();
    wr(ADDR_CTRL0, 32'h86);
    wv(1'b0);
    chk(out_level, 32'h5, "reserved mode inactive");
    wv(1'b1);
    chk(out_level, 32'h5, "reserved mode no waveform");
    wr(ADDR_CTRL0, 32'h82);
  endtask

  task automatic t_sleep();
    @(posedge pclk);
    sleep_req      <= 1'b1;
    input_active   <= 1'b1;
    hfosc_selected <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(osc_keep_on, 32'h1, "osc kept in sleep");
    chk(out_level[0], 32'h0, "runs in sleep");
    @(posedge pclk);
    hfosc_selected <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(osc_keep_on, 32'h0, "other clock selected");
    @(posedge pclk);
    hfosc_selected <= 1'b1;
    wr(ADDR_CTRL0, 32'h02);
    repeat (2) @(posedge pclk);
    chk(osc_keep_on, 32'h0, "disabled lets osc stop");
    @(posedge pclk);
    sleep_req <= 1'b0;
  endtask

  // every generating mode except forward, dead-band timing, then the remaining override codes
  task automatic t_modes();
    logic [3:0] p;
    wr(ADDR_CTRL0, 32'h80);
    wr(ADDR_OUTSEL, 32'h1f);
    wv(1'b0);
    chk(out_level, 32'h5, "steer low");
    wv(1'b1);
    chk(out_level, 32'h4, "steer a follows input");
    wr(ADDR_CTRL0, 32'h81);
    wr(ADDR_OUTSEL, 32'h2f);
    wv(1'b1);
    chk(out_level, 32'h4, "sync steer waits for rise");
    wv(1'b0);
    wv(1'b1);
    chk(out_level, 32'h7, "sync steer moved on rise");
    wr(ADDR_CTRL0, 32'h83);
    wv(1'b0);
    wv(1'b1);
    chk(out_level, 32'h1, "reverse b held by dead band");
    @(posedge pclk);
    chk(out_level, 32'h3, "reverse b after dead band");
    wr(ADDR_CTRL0, 32'h84);
    wv(1'b1);
    chk(out_level, 32'h0, "half bridge a/c on");
    wv(1'b0);
    chk(out_level, 32'h5, "half bridge dead band gap");
    @(posedge pclk);
    chk(out_level, 32'hf, "half bridge b/d on");
    wr(ADDR_CTRL0, 32'h85);
    wv(1'b1);
    p = out_level;
    wv(1'b0);
    wv(1'b1);
    chk(out_level[1:0] ^ p[1:0], 32'h3, "push-pull alternates");
    chk(out_level[1] ^ out_level[0], 32'h0, "push-pull one side at a time");
    chk(out_level[3:2], 32'h1, "push-pull c/d inactive");
    wr(ADDR_SDCTRL, 32'h98);
    repeat (2) @(posedge pclk);
    chk(out_level, 32'h0, "a/c zero, polarity ignored");
    chk(out_oe, 32'h5, "b/d tristated");
    wr(ADDR_SDCTRL, 32'h80);
    repeat (2) @(posedge pclk);
    chk(out_level, 32'h5, "inactive level keeps polarity");
    chk(out_oe, 32'hf, "inactive level driven");
  endtask

  // every input valued at time zero, reset held four cycles
  initial begin
    miscompares = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wave_in = 1'b0;
    shutdown_source = '0;
    sleep_req = 1'b0;
    input_active = 1'b0;
    hfosc_selected = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_config();
    t_soft_restart();
    t_auto_restart();
    t_reserved();
    t_sleep();
    t_modes();
    end_sim();
  end
endmodule
